// >>> hdl/ics_core.sv
// interrupt entry/exit, vector selection, return stack and shadow registers
`timescale 1ns/1ps
module ics_core import ics_pkg::*; #(
    parameter int DEPTH = ICS_STACK_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // external request lines, one-cycle pulses or levels
    input wire logic [3:0] external_user_irq_lines,
    input wire logic nmi_line,
    // internal peripheral requests
    input wire logic timer_req,
    input wire logic ser_rx_req,
    input wire logic ser_tx_req,
    input wire logic tdm_rx_req,
    input wire logic tdm_tx_req,
    // per-source enables (mask bits kept outside)
    input wire logic [8:0] irq_enable,
    // instruction strobes from the decoder
    input wire logic software_vector_call,
    input wire logic [4:0] software_vector_num,
    input wire logic trap_instr,
    input wire logic soft_nmi_instr,
    input wire logic irq_return,
    input wire logic irq_return_with_enable,
    input wire logic call_instr,
    input wire logic ret_instr,
    input wire logic acc_push,
    input wire logic acc_pop,
    input wire logic push_from_memory,
    input wire logic pop_to_memory,
    input wire logic [15:0] mem_rdata,
    input wire logic [15:0] call_target,
    input wire logic int_mask_set,
    input wire logic int_mask_clr,
    // live context from the datapath
    input wire logic [15:0] pc,
    input wire ics_ctx_t ctx_live,
    // results
    output logic pc_load,
    output logic [15:0] pc_next,
    output logic ctx_restore,
    output ics_ctx_t ctx_out,
    output logic acc_load,
    output logic [15:0] acc_data,
    output logic mem_write,
    output logic [15:0] mem_wdata,
    output logic global_irq_mask,
    output logic [9:0] irq_pending,
    output logic [4:0] vector_taken,
    output logic [3:0] stack_level
);
    // the level port is four bits wide and the check admits only the eight-entry stack
    if (DEPTH != ICS_STACK_DEPTH) begin : g_depth_check
        $error("stack depth must match the level port");
    end
    //////////////////////////////////////////////////////////////////////////
    // state
    // outputs but stack_level live in this struct: each leaves a flop,
    // at the cost of one cycle from strobe to answer
    typedef struct packed {
        ics_ctx_t shadow;                 // one-deep copy
        logic [9:0] pend;                 // pending hardware requests
        logic mask;                       // global_irq_mask
        logic pc_load;
        logic [15:0] pc_next;
        logic ctx_restore;
        ics_ctx_t ctx_out;
        logic acc_load;
        logic [15:0] acc_data;
        logic mem_write;
        logic [15:0] mem_wdata;
        logic [4:0] vec;
    } ics_core_state_t;
    ics_core_state_t state, next_state;
    // combinational helpers, only stk_level reaches a port
    ics_stk_op_t stk_op;                  // stack command this cycle
    logic [15:0] stk_push;                // value pushed
    logic [15:0] stk_top;                 // current top
    logic [3:0] stk_level;                // entries held
    logic [9:0] req_now;                  // raw requests this cycle
    logic [9:0] eligible;                 // pending and allowed
    logic take_hw;                        // hardware request accepted
    logic take_sw;                        // software vector taken
    logic [4:0] hw_vec;                   // vector of chosen source
    logic [4:0] sel_vec;                  // vector of this entry
    logic [9:0] taken_bit;                // pending bit cleared on entry
    logic do_ret;                         // either return form
    logic [4:0] vptr;                     // vector table pointer
    logic [4:0] src_vec [10];             // vector per source
    //////////////////////////////////////////////////////////////////////////
    // source map: bit 9 is the nonmaskable line
    // fixed table so the search below is one loop
    always_comb begin
        src_vec[0] = ICS_VEC_USER1;
        src_vec[1] = ICS_VEC_USER2;
        src_vec[2] = ICS_VEC_USER3;
        src_vec[3] = ICS_VEC_USER4;
        src_vec[4] = ICS_VEC_TIMER;
        src_vec[5] = ICS_VEC_SER_RX;
        src_vec[6] = ICS_VEC_SER_TX;
        src_vec[7] = ICS_VEC_TDM_RX;
        src_vec[8] = ICS_VEC_TDM_TX;
        src_vec[9] = ICS_VEC_NMI;
    end
    // gather requests
    // bit order must match irq_enable and src_vec;
    // user line four is bit 3 but vector 9
    // a level pends again on every cycle it stays high
    always_comb begin
        req_now = {nmi_line, tdm_tx_req, tdm_rx_req, ser_tx_req, ser_rx_req, timer_req,
                   external_user_irq_lines[3], external_user_irq_lines[2:0]};
    end
    // pick a source: nonmaskable first, then lowest maskable bit
    // the nonmaskable bit ignores mask and enables;
    // the loop runs down so the lowest bit wins
    always_comb begin
        eligible = state.pend & {1'b1, irq_enable & {9{~state.mask}}};
        take_hw = 1'b0;
        hw_vec = '0;
        taken_bit = '0;
        if (eligible[9]) begin
            take_hw = 1'b1;
            hw_vec = src_vec[9];
            taken_bit[9] = 1'b1;
        end else begin
            for (int i = 8; i >= 0; i--) begin
                if (eligible[i]) begin
                    take_hw = 1'b1;
                    hw_vec = src_vec[i];
                    taken_bit = '0;
                    taken_bit[i] = 1'b1;
                end
            end
        end
    end
    // software requests win over hardware ones in the same cycle
    // a strobe is an instruction in the pipe, so it
    // goes first; hardware stays pending until it is taken
    always_comb begin
        take_sw = software_vector_call | trap_instr | soft_nmi_instr;
        if (software_vector_call) begin
            sel_vec = software_vector_num;
        end else if (trap_instr) begin
            sel_vec = ICS_VEC_TRAP;
        end else if (soft_nmi_instr) begin
            sel_vec = ICS_VEC_NMI;
        end else begin
            sel_vec = hw_vec;
        end
    end
    // both returns restore alike; only the mask differs
    // pointer read live: a moved table acts at once
    assign do_ret = irq_return | irq_return_with_enable;
    assign vptr = ctx_live.processor_mode_status[ICS_MODE_PTR_LSB +: ICS_PTR_W];
    //////////////////////////////////////////////////////////////////////////
    // stack command
    // one stack operation per cycle, in strobe priority
    // calls share the stack with interrupt entries
    // acc push takes the low half: the stack is pc wide
    always_comb begin
        stk_op = ICS_STK_NONE;
        stk_push = '0;
        if (take_sw | take_hw) begin
            stk_op = ICS_STK_PUSH;
            stk_push = pc;
        end else if (do_ret | ret_instr) begin
            stk_op = ICS_STK_POP;
        end else if (call_instr) begin
            stk_op = ICS_STK_PUSH;
            stk_push = pc;
        end else if (acc_push) begin
            stk_op = ICS_STK_PUSH;
            stk_push = ctx_live.acc[15:0];
        end else if (push_from_memory) begin
            stk_op = ICS_STK_PUSH;
            stk_push = mem_rdata;
        end else if (acc_pop | pop_to_memory) begin
            stk_op = ICS_STK_POP;
        end
    end
    // return stack; overflow past eight is software's problem
    // a ninth push drops the bottom entry, a pop at
    // zero keeps zero; neither is flagged
    ics_ret_stack #(
        .DEPTH(DEPTH),
        .WIDTH(ICS_PC_W)
    ) u_stack (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .op(stk_op),
        .push_data(stk_push),
        .top(stk_top),
        .level(stk_level)
    );
    //////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_state = state;
        // pulses drop unless a branch raises them
        next_state.pc_load = 1'b0;
        next_state.ctx_restore = 1'b0;
        next_state.acc_load = 1'b0;
        next_state.mem_write = 1'b0;
        // new requests set pending; set beats the clear on entry
        // a source raised while served pends again
        next_state.pend = (state.pend & ~(take_sw ? 10'h000 : taken_bit)) | req_now;
        // entry below overrides: a routine starts masked
        if (int_mask_set) begin
            next_state.mask = 1'b1;
        end else if (int_mask_clr) begin
            next_state.mask = 1'b0;
        end
        if (take_sw | take_hw) begin
            // entry: save context, mask, branch
            // saved on the branching edge: never half saved
            next_state.shadow = ctx_live;
            next_state.mask = 1'b1;
            next_state.pc_load = 1'b1;
            next_state.pc_next = ({11'h000, vptr} << ICS_PAGE_SHIFT)
                | ({11'h000, sel_vec} << ICS_VEC_STRIDE_SHIFT);
            // vector number kept as status
            next_state.vec = sel_vec;
        end else if (do_ret) begin
            // return: restore all but the mask and flag bits
            // mask from the core, flag from the datapath:
            // the restore rolls back neither
            next_state.ctx_restore = 1'b1;
            next_state.ctx_out = state.shadow;
            next_state.ctx_out.st0[ICS_ST0_MASK_BIT] = state.mask;
            next_state.ctx_out.st1[ICS_ST1_FLAG_BIT] = ctx_live.st1[ICS_ST1_FLAG_BIT];
            next_state.pc_load = 1'b1;
            next_state.pc_next = stk_top;
            // only the enabling form opens the mask again
            if (irq_return_with_enable) next_state.mask = 1'b0;
        end else if (ret_instr) begin
            // subroutine return: pc only
            next_state.pc_load = 1'b1;
            next_state.pc_next = stk_top;
        end else if (call_instr) begin
            next_state.pc_load = 1'b1;
            // return address pushed by the stack command
            next_state.pc_next = call_target;
        end else if (acc_pop) begin
            next_state.acc_load = 1'b1;
            // top read before this edge's pop
            next_state.acc_data = stk_top;
        end else if (pop_to_memory) begin
            next_state.mem_write = 1'b1;
            // address stays with the decoder
            next_state.mem_wdata = stk_top;
        end
    end
    // register the state; reset clears pending, sets mask, pc at zero
    // constants only; a cleared shadow means a return
    // straight after reset restores zeros
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
            state.mask <= 1'b1;
            state.ctx_out.st0 <= ICS_ST0_RESET;
            state.ctx_out.processor_mode_status <= ICS_MODE_RESET;
        end else begin
            state <= next_state;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // outputs, all from flops except the stack level which is a flop in the child
    // pc_next and data outputs hold between pulses
    // stack_level comes from the child's counter flop
    assign pc_load = state.pc_load;
    assign pc_next = state.pc_next;
    assign ctx_restore = state.ctx_restore;
    assign ctx_out = state.ctx_out;
    assign acc_load = state.acc_load;
    assign acc_data = state.acc_data;
    assign mem_write = state.mem_write;
    assign mem_wdata = state.mem_wdata;
    assign global_irq_mask = state.mask;
    assign irq_pending = state.pend;
    assign vector_taken = state.vec;
    assign stack_level = stk_level;
endmodule : ics_core

// >>> inc/ics_pkg.sv
// shared constants and types for the interrupt context stack
package ics_pkg;
    localparam int ICS_PC_W = 16;                         // program address width
    localparam int ICS_STACK_DEPTH = 8;                   // return-address stack entries
    localparam int ICS_VEC_COUNT = 32;                    // vector table entries
    localparam int ICS_VEC_RESERVED = 20;                 // entries for hardware sources
    localparam int ICS_VEC_W = 5;                         // vector number width
    localparam int ICS_PTR_W = 5;                         // vector table pointer width (page number)
    localparam int ICS_VEC_STRIDE_SHIFT = 1;              // two words per vector slot
    localparam int ICS_PAGE_SHIFT = 11;                   // page size of vector table
    localparam logic [4:0] ICS_IRQ_W = 5'h0a;             // count of hardware request sources
    // reset, hardware source and trap vector numbers
    localparam logic [4:0] ICS_VEC_RESET = 5'h00;
    localparam logic [4:0] ICS_VEC_USER1 = 5'h01;
    localparam logic [4:0] ICS_VEC_USER2 = 5'h02;
    localparam logic [4:0] ICS_VEC_USER3 = 5'h03;
    localparam logic [4:0] ICS_VEC_TIMER = 5'h04;
    localparam logic [4:0] ICS_VEC_SER_RX = 5'h05;
    localparam logic [4:0] ICS_VEC_SER_TX = 5'h06;
    localparam logic [4:0] ICS_VEC_TDM_RX = 5'h07;
    localparam logic [4:0] ICS_VEC_TDM_TX = 5'h08;
    localparam logic [4:0] ICS_VEC_USER4 = 5'h09;
    localparam logic [4:0] ICS_VEC_TRAP = 5'h11;
    localparam logic [4:0] ICS_VEC_NMI = 5'h12;
    // status register bit positions
    localparam int ICS_ST0_MASK_BIT = 9;                  // global_irq_mask inside status 0
    localparam int ICS_ST1_FLAG_BIT = 4;                  // external_flag_output inside status 1
    // reset values
    localparam logic [15:0] ICS_ST0_RESET = 16'h0200;     // mask set
    localparam logic [15:0] ICS_ST1_RESET = 16'h0000;
    localparam logic [15:0] ICS_MODE_RESET = 16'h0000;    // pointer cleared
    localparam int ICS_MODE_PTR_LSB = 11;                 // pointer field in processor_mode_status
    // register context that has a shadow copy
    typedef struct packed {
        logic [31:0] acc;
        logic [31:0] acc_buf;
        logic [31:0] prod;
        logic [15:0] st0;
        logic [15:0] st1;
        logic [15:0] processor_mode_status;
        logic [15:0] tmp_mul;
        logic [15:0] tmp_shift;
        logic [15:0] tmp_bit;
        logic [15:0] index;
        logic [15:0] aux_cmp;
    } ics_ctx_t;
    // stack operation codes
    typedef enum logic [1:0] {ICS_STK_NONE, ICS_STK_PUSH, ICS_STK_POP} ics_stk_op_t;
endpackage : ics_pkg

// >>> hdl/ics_ret_stack.sv
// eight-entry hardware return-address stack
`timescale 1ns/1ps
module ics_ret_stack import ics_pkg::*; #(
    parameter int DEPTH = ICS_STACK_DEPTH,
    parameter int WIDTH = ICS_PC_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // operation
    input wire ics_stk_op_t op,
    input wire logic [WIDTH-1:0] push_data,
    // state
    output logic [WIDTH-1:0] top,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int LW = $clog2(DEPTH+1);
    if (DEPTH < 2) begin : g_depth_check
        $error("stack depth too small");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] ent;
        logic [LW-1:0] cnt;
    } ics_stk_state_t;
    ics_stk_state_t state, next_state;
    // shift-register stack: a push beyond depth drops the bottom entry, a pop
    // duplicates the bottom, as a fixed hardware stack does
    always_comb begin
        next_state = state;
        if (op == ICS_STK_PUSH) begin
            next_state.ent[0] = push_data;
            for (int i = 1; i < DEPTH; i++) begin
                next_state.ent[i] = state.ent[i-1];
            end
            if (state.cnt != LW'(DEPTH)) next_state.cnt = state.cnt + LW'(1);
        end else if (op == ICS_STK_POP) begin
            for (int i = 0; i < DEPTH-1; i++) begin
                next_state.ent[i] = state.ent[i+1];
            end
            if (state.cnt != '0) next_state.cnt = state.cnt - LW'(1);
        end
    end
    // register the state
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign top = state.ent[0];
    assign level = state.cnt;
endmodule : ics_ret_stack

// >>> verification/ics_core_assertions.sv
// concurrent checks on the ports of the interrupt context stack
`timescale 1ns/1ps
module ics_core_assertions import ics_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // instruction strobes
    input wire logic software_vector_call,
    input wire logic [4:0] software_vector_num,
    input wire logic trap_instr,
    input wire logic soft_nmi_instr,
    input wire logic irq_return,
    input wire logic irq_return_with_enable,
    input wire logic ret_instr,
    input wire logic call_instr,
    input wire logic acc_push,
    input wire logic acc_pop,
    input wire logic push_from_memory,
    input wire logic pop_to_memory,
    input wire logic int_mask_set,
    input wire ics_ctx_t ctx_live,
    // results
    input wire logic pc_load,
    input wire logic [15:0] pc_next,
    input wire logic ctx_restore,
    input wire ics_ctx_t ctx_out,
    input wire logic mem_write,
    input wire logic global_irq_mask,
    input wire logic [9:0] irq_pending,
    input wire logic [4:0] vector_taken,
    input wire logic [3:0] stack_level
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // entry may be pending even when masked, so this is deliberately wider than needed
    wire logic ent = software_vector_call | trap_instr | soft_nmi_instr | (irq_pending != 10'h000);
    wire logic hi = ent | irq_return | irq_return_with_enable | ret_instr | call_instr;
    ////////////////////////////////////////////////////////////////////////////////
    a_swcall_vector: assert property (software_vector_call |=> pc_load && global_irq_mask
        && vector_taken == $past(software_vector_num) && pc_next == {$past(ctx_live.processor_mode_status[15:11]),
        5'h00, $past(software_vector_num), 1'b0}) else $error("software call vector wrong");
    a_trap_vector: assert property (trap_instr && !software_vector_call |=> pc_load
        && vector_taken == ICS_VEC_TRAP) else $error("trap vector wrong");
    a_return_mask: assert property (irq_return && !ent |=> ctx_restore
        && ctx_out.st0[ICS_ST0_MASK_BIT] == $past(global_irq_mask)) else $error("mask bit not kept");
    a_return_flag: assert property (ctx_restore |->
        ctx_out.st1[ICS_ST1_FLAG_BIT] == $past(ctx_live.st1[ICS_ST1_FLAG_BIT])) else $error("flag bit not kept");
    a_return_enable: assert property (irq_return_with_enable && !ent && !irq_return |=>
        ctx_restore && !global_irq_mask) else $error("return with enable failed");
    a_push_level: assert property (acc_push && !hi && stack_level < 4'h8 |=>
        stack_level == $past(stack_level) + 4'h1) else $error("push level wrong");
    a_pop_memory: assert property (pop_to_memory && !hi && !acc_push && !push_from_memory && !acc_pop
        && stack_level != 4'h0 |=> mem_write && stack_level == $past(stack_level) - 4'h1) else $error("memory pop wrong");
    a_level_bound: assert property (stack_level <= 4'h8) else $error("stack deeper than eight");
    a_mask_set: assert property (int_mask_set && !irq_return_with_enable |=> global_irq_mask)
        else $error("mask not set");
    // main scenarios reached
    c_swcall: cover property (software_vector_call ##1 pc_load);
    c_restore: cover property (ctx_restore);
    c_mem_pop: cover property (mem_write);
endmodule : ics_core_assertions

// >>> verification/ics_ctx_model.sv
// datapath stand-in holding program counter and live context beside the core
`timescale 1ns/1ps
module ics_ctx_model import ics_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // loads from the core
    input wire logic pc_load,
    input wire logic [15:0] pc_next,
    input wire logic ctx_restore,
    input wire ics_ctx_t ctx_out,
    input wire logic acc_load,
    input wire logic [15:0] acc_data,
    // live state
    output logic [15:0] pc,
    output ics_ctx_t ctx_live
);
    ////////////////////////////////////////////////////////////////////////////////
    // context drifts on every cycle without a restore so a stale restore or a stale flag shows up
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc <= 16'h0000;
            ctx_live <= '0;
            ctx_live.st0 <= ICS_ST0_RESET;
            ctx_live.processor_mode_status <= ICS_MODE_RESET;
        end else begin
            pc <= pc_load ? pc_next : pc + 16'h0001;
            if (ctx_restore) begin
                ctx_live <= ctx_out;
            end else begin
                ctx_live.acc <= ctx_live.acc + 32'h00010003;
                ctx_live.st1 <= ctx_live.st1 ^ 16'h0010;
                ctx_live.aux_cmp <= ctx_live.aux_cmp + 16'h0001;
            end
            if (acc_load) ctx_live.acc[15:0] <= acc_data;
        end
    end
endmodule : ics_ctx_model

// >>> verification/ics_core_bench.sv
// self-checking bench for the interrupt context stack
`timescale 1ns/1ps
module ics_core_bench import ics_pkg::*; ;
    // strobe positions inside st
    localparam int SW = 0, TR = 1, SN = 2, RI = 3, RE = 4, CL = 5, RT = 6;
    localparam int AP = 7, AO = 8, MP = 9, MO = 10, MS = 11, MC = 12;
    // vector expected per request line
    localparam logic [4:0] HWV [10] = '{5'h01, 5'h02, 5'h03, 5'h09, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h12};
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [12:0] st = '0; // instruction strobes
    logic [9:0] src = '0; // request lines, bit9 nonmaskable
    logic [8:0] en = 9'h1ff;
    logic [4:0] num = 5'h00;
    logic [15:0] mrd = 16'h0000, tgt = 16'h0000, spc, cpc;
    wire logic [15:0] pc, pc_next, acc_data, mem_wdata;
    wire ics_ctx_t ctx_live, ctx_out;
    wire logic pc_load, ctx_restore, acc_load, mem_write, global_irq_mask;
    wire logic [9:0] irq_pending;
    wire logic [4:0] vector_taken;
    wire logic [3:0] stack_level;
    ics_ctx_t sctx, cctx, e;
    logic sm;
    logic [15:0] pushed [9];
    int errors = 0, checked = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    ics_core i_ics_core (.core_clk(core_clk), .arst_n(arst_n), .external_user_irq_lines(src[3:0]),
        .nmi_line(src[9]), .timer_req(src[4]), .ser_rx_req(src[5]), .ser_tx_req(src[6]), .tdm_rx_req(src[7]),
        .tdm_tx_req(src[8]), .irq_enable(en), .software_vector_call(st[SW]), .software_vector_num(num),
        .trap_instr(st[TR]), .soft_nmi_instr(st[SN]), .irq_return(st[RI]), .irq_return_with_enable(st[RE]),
        .call_instr(st[CL]), .ret_instr(st[RT]), .acc_push(st[AP]), .acc_pop(st[AO]),
        .push_from_memory(st[MP]), .pop_to_memory(st[MO]), .mem_rdata(mrd), .call_target(tgt),
        .int_mask_set(st[MS]), .int_mask_clr(st[MC]), .pc(pc), .ctx_live(ctx_live), .pc_load(pc_load),
        .pc_next(pc_next), .ctx_restore(ctx_restore), .ctx_out(ctx_out), .acc_load(acc_load), .acc_data(acc_data),
        .mem_write(mem_write), .mem_wdata(mem_wdata), .global_irq_mask(global_irq_mask),
        .irq_pending(irq_pending), .vector_taken(vector_taken), .stack_level(stack_level));
    ics_ctx_model i_ics_ctx_model (.core_clk(core_clk), .arst_n(arst_n), .pc_load(pc_load), .pc_next(pc_next),
        .ctx_restore(ctx_restore), .ctx_out(ctx_out), .acc_load(acc_load), .acc_data(acc_data), .pc(pc),
        .ctx_live(ctx_live));
    ////////////////////////////////////////////////////////////////////////////////
    always #2 core_clk = ~core_clk;
    // a hang is cut short well past the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [$bits(ics_ctx_t)-1:0] seen, input logic [$bits(ics_ctx_t)-1:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one strobe for one cycle; captures what the core samples on the taking edge
    task automatic pulse(input int b);
        @(negedge core_clk);
        st[b] = 1'b1;
        spc = pc;
        sctx = ctx_live;
        sm = global_irq_mask;
        @(negedge core_clk);
        st = '0;
    endtask : pulse
    task automatic raise(input int k);
        @(negedge core_clk);
        src[k] = 1'b1;
        @(negedge core_clk);
        src = '0;
    endtask : raise
    // bounded wait for entry, then the vector is compared
    task automatic wait_entry(input logic [4:0] v);
        for (int i = 0; i < 10 && pc_load !== 1'b1; i++) @(negedge core_clk);
        chk(vector_taken, v);
    endtask : wait_entry
    task automatic print_verdict();
        if (errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge core_clk);
        chk(global_irq_mask, 1'b1);
        chk(irq_pending, 10'h000);
        arst_n = 1'b1;
        // every software vector, then a return that must undo the context
        for (int v = 0; v < 32; v++) begin
            num = v[4:0];
            pulse(SW);
            cpc = spc;
            cctx = sctx;
            chk(pc_next, {10'h000, v[4:0], 1'b0});
            chk(global_irq_mask, 1'b1);
            if (v[0]) pulse(MC);
            pulse(RI);
            e = cctx;
            e.st0[ICS_ST0_MASK_BIT] = sm;
            e.st1[ICS_ST1_FLAG_BIT] = sctx.st1[ICS_ST1_FLAG_BIT];
            chk(ctx_restore, 1'b1);
            chk(ctx_out, e);
            chk(pc_next, cpc);
        end
        pulse(TR);
        chk(vector_taken, ICS_VEC_TRAP);
        pulse(RE);
        chk(global_irq_mask, 1'b0);
        pulse(SN);
        chk(vector_taken, ICS_VEC_NMI);
        pulse(RI);
        // each hardware request line in turn
        for (int k = 0; k < 10; k++) begin
            pulse(MC);
            raise(k);
            wait_entry(HWV[k]);
            pulse(RI);
        end
        // masked request is held until the mask drops
        pulse(MS);
        raise(0);
        repeat (3) begin
            @(negedge core_clk);
            chk(pc_load, 1'b0);
        end
        chk(|irq_pending, 1'b1);
        // mask dropped but the source disabled: it stays pending
        en = 9'h1fe;
        pulse(MC);
        @(negedge core_clk);
        chk(pc_load, 1'b0);
        en = 9'h1ff;
        wait_entry(5'h01);
        pulse(RI);
        tgt = 16'h1234;
        pulse(CL);
        cpc = spc;
        chk(pc_next, 16'h1234);
        pulse(RT);
        chk(pc_next, cpc);
        // fill to eight, the most held without a spill, then empty both ways
        for (int v = 0; v < 8; v++) begin
            pulse(AP);
            pushed[v] = sctx.acc[15:0];
        end
        chk(stack_level, 4'h8);
        for (int v = 7; v >= 0; v--) begin
            pulse(v[0] ? AO : MO);
            chk(v[0] ? acc_load : mem_write, 1'b1);
            chk(v[0] ? acc_data : mem_wdata, pushed[v]);
        end
        chk(stack_level, 4'h0);
        mrd = 16'h5a5a;
        pulse(MP);
        pulse(AO);
        chk(acc_data, 16'h5a5a);
        print_verdict();
    end
endmodule : ics_core_bench
bind ics_core ics_core_assertions i_ics_core_assertions (.core_clk(core_clk), .arst_n(arst_n),
    .software_vector_call(software_vector_call), .software_vector_num(software_vector_num),
    .trap_instr(trap_instr), .soft_nmi_instr(soft_nmi_instr), .irq_return(irq_return),
    .irq_return_with_enable(irq_return_with_enable), .ret_instr(ret_instr), .call_instr(call_instr),
    .acc_push(acc_push), .acc_pop(acc_pop), .push_from_memory(push_from_memory), .pop_to_memory(pop_to_memory),
    .int_mask_set(int_mask_set), .ctx_live(ctx_live), .pc_load(pc_load), .pc_next(pc_next),
    .ctx_restore(ctx_restore), .ctx_out(ctx_out), .mem_write(mem_write), .global_irq_mask(global_irq_mask),
    .irq_pending(irq_pending), .vector_taken(vector_taken), .stack_level(stack_level));
